// [testbench/power_switch_model.sv]
`timescale 1ns/10ps

// behavioural switch: decode, lockout, fault line
module power_switch_model #(
  parameter int FAULT_CYCLES = 160000
) (
  // clock and rail
  input wire logic clk,
  input wire logic rail_ok,
  // fault stimulus
  input wire logic overcurrent,
  input wire logic overtemp,
  // select lines
  input wire logic state_select_bit0,
  input wire logic state_select_bit1,
  input wire logic state_select_bit2,
  // levels: 0 ground, 1 low rail, 2 high rail, 3 open
  output logic [1:0] main_out,
  output logic [1:0] aux1_out,
  output logic [1:0] aux2_out,
  output logic fault_low
);
  // main, aux1, aux2 level per select code
  localparam logic [5:0] LEVELS [8] = '{6'h15, 6'h1a, 6'h3f, 6'h33, 6'h12, 6'h18, 6'h10, 6'h00};
  logic [2:0] sel;
  int oc_cnt = 0;

  // lockout opens every switch
  assign sel = {state_select_bit2, state_select_bit1, state_select_bit0};
  assign {main_out, aux1_out, aux2_out} = rail_ok ? LEVELS[sel] : 6'h3f;

  // overcurrent must persist before the line rises
  always @(posedge clk)
  begin
    if (!overcurrent)
      oc_cnt <= 0;
    else if (oc_cnt < FAULT_CYCLES)
      oc_cnt <= oc_cnt + 1;
  end
  assign fault_low = rail_ok & (overtemp | (oc_cnt >= FAULT_CYCLES));
endmodule : power_switch_model

// [testbench/test_card_slot_power_sequencer.sv]
`timescale 1ns/10ps

module test_card_slot_power_sequencer
  import slot_power_pkg::*;
;
  typedef struct packed {logic [7:0] v; logic [11:0] w; logic [2:0] c;} row_t;
  localparam int FC = 20;
  logic clk = 0;
  logic rst = 1;
  logic hm = 0, acc = 0, pr = 0, cm = 0, dd = 0, dm = 0, ch = 0, rq = 0, gr = 0;
  logic oc = 0, ot = 0, dr = 1, dp = 1;
  logic b0, b1, b2, crst, smode, fseen, flow;
  logic [2:0] code;
  int errors = 0, num_checks = 0, cyc = 0;
  // flags r hm pr cm dd dm rq gr, cycles, expected code
  row_t rows [16] = '{
    '{8'h80, 12'd2, CODE_ALL_LOW},
    '{8'h22, 12'd1, CODE_ALL_LOW},
    '{8'h23, 12'd1, CODE_ALL_LOW},
    '{8'h00, 12'd2005, CODE_ALL_LOW},
    '{8'h23, 12'd1, CODE_AUX_HIGH},
    '{8'h20, 12'd5, CODE_AUX_HIGH},
    '{8'h00, 12'd1, CODE_AUX_DISCH},
    '{8'h00, 12'd2005, CODE_ALL_LOW},
    '{8'hc0, 12'd1, CODE_ALL_GND},
    '{8'h40, 12'd2005, CODE_ALL_OPEN},
    '{8'h70, 12'd1, CODE_HOST_SIG},
    '{8'h7c, 12'd1, CODE_MULTI_ON},
    '{8'h70, 12'd5, CODE_MULTI_ON},
    '{8'h40, 12'd1, CODE_ALL_GND},
    '{8'h40, 12'd2005, CODE_ALL_OPEN},
    '{8'h60, 12'd5, CODE_ALL_OPEN}
  };

  // clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      final_report();
    end
  end
  assign code = {b2, b1, b0};

  slot_power_host dut (
    .clk(clk), .rst(rst), .host_is_multi(hm), .accept_single_card(acc),
    .discharge_on_removal(dr), .discharge_on_powerup(dp), .card_present(pr),
    .card_is_multi(cm), .id_done(dd), .id_multi(dm), .id_channel_one_support(ch),
    .info_request(rq), .info_grant(gr), .fault_n(!flow), .state_select_bit0(b0),
    .state_select_bit1(b1), .state_select_bit2(b2), .card_reset(crst),
    .single_mode(smode), .fault_seen(fseen)
  );
  power_switch_model #(.FAULT_CYCLES(FC)) u_sw (
    .clk(clk), .rail_ok(1'b1), .overcurrent(oc), .overtemp(ot),
    .state_select_bit0(b0), .state_select_bit1(b1), .state_select_bit2(b2),
    .main_out(), .aux1_out(), .aux2_out(), .fault_low(flow)
  );

  task final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task check(string n, logic [2:0] e, logic [2:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : check

  task run_row(row_t r);
    @(posedge clk);
    {hm, pr, cm, dd, dm, rq, gr} <= r.v[6:0];
    if (r.v[7])
    begin
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
    end
    repeat (r.w) @(posedge clk);
    @(negedge clk);
  endtask : run_row

  // single card identified by the multi host, accepted or not
  task single_id(logic a);
    @(posedge clk);
    acc <= a;
    {pr, cm} <= 2'b11;
    repeat (2) @(posedge clk);
    {dd, dm, ch} <= 3'b101;
    @(posedge clk);
    dd <= 1'b0;
    @(negedge clk);
    check("card_reset", {2'b00, a}, {2'b00, crst});
    @(negedge clk);
    check("pulse end", 3'h0, {2'b00, crst});
    check("single_mode", {2'b00, a}, {2'b00, smode});
    check("powered", {2'b00, a}, {2'b00, !(code inside {3'h2, 3'h3, 3'h7})});
    @(posedge clk);
    {pr, cm, ch} <= 3'b000;
    repeat (2005) @(posedge clk);
    @(negedge clk);
    check("after removal", CODE_ALL_OPEN, code);
    check("mode cleared", 3'h0, {2'b00, smode});
  endtask : single_id

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      run_row(rows[i]);
      check("code", rows[i].c, code);
    end
    // reset in mid-run opens every output
    @(posedge clk);
    rst <= 1'b1;
    {pr, cm} <= 2'b00;
    @(negedge clk);
    check("reset code", CODE_RESET, code);
    check("reset flags", 3'h0, {crst, smode, fseen});
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2005) @(posedge clk);
    single_id(1'b0);
    single_id(1'b1);
    // multi host powers up straight to 010 when no discharge is wanted
    @(posedge clk);
    {dr, dp} <= 2'b00;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    {pr, cm} <= 2'b11;
    @(negedge clk);
    check("powerup direct", CODE_ALL_OPEN, code);
    @(negedge clk);
    check("detect direct", CODE_HOST_SIG, code);
    // single host returns straight to 000 on removal without discharge
    @(posedge clk);
    {hm, pr, cm} <= 3'b000;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    {pr, rq, gr} <= 3'b111;
    @(posedge clk);
    {rq, gr} <= 2'b00;
    @(negedge clk);
    check("grant direct", CODE_AUX_HIGH, code);
    @(posedge clk);
    pr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("removal direct", CODE_ALL_LOW, code);
    // overcurrent needs persistence, overtemp does not
    @(posedge clk);
    oc <= 1'b1;
    repeat (FC - 2) @(posedge clk);
    @(negedge clk);
    check("fault early", 3'h0, {2'b00, fseen});
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("fault late", 3'h1, {2'b00, fseen});
    @(posedge clk);
    {oc, ot} <= 2'b01;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("overtemp", 3'h1, {2'b00, fseen});
    final_report();
  end
endmodule : test_card_slot_power_sequencer

// [verilog/dwell_timer.sv]
`timescale 1ns/10ps

// down counter that reports when a discharge dwell has run out
module dwell_timer
  import slot_power_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  // status
  output logic expired
);

  typedef struct packed {
    logic [DWELL_W-1:0] count;
  } timer_t;

  timer_t cur_q;
  timer_t nxt_d;

  // reload on request, count down to zero otherwise
  always_comb
  begin
    nxt_d = cur_q;
    if (load)
    begin
      nxt_d.count = DWELL_LOAD;
    end
    else if (cur_q.count != DWELL_ZERO)
    begin
      nxt_d.count = cur_q.count - 12'h001;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_q <= '0;
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  assign expired = (cur_q.count == DWELL_ZERO) && !load;

endmodule : dwell_timer

// [verilog/slot_power_host.sv]
`timescale 1ns/10ps

// Behaviour
// RULE_01: switch disables outputs while low rail low
// RULE_02: switch decodes eight select codes to outputs
// RULE_03: host picks codes per mode and event
// RULE_04: mode chosen from host and card types
// RULE_05: unaccepted single card never gets power
// RULE_06: single host holds 000 after power-up
// RULE_07: refused request keeps 000, even on removal
// RULE_08: granted request holds 001 until removal
// RULE_09: removal returns to 000, optional 110
// RULE_10: multi host power-up via 111 to 010
// RULE_11: multi host holds 010 without card
// RULE_12: multi card detected moves to 011
// RULE_13: confirmed multi card gets 100 until removal
// RULE_14: channel-one single card goes single mode
// RULE_15: other cards stay unpowered until removal
// RULE_16: multi removal passes 111 then 010
// RULE_17: switch fault output delayed for overcurrent
// RULE_18: all select bits change on one edge
module slot_power_host
  import slot_power_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host configuration
  input wire logic host_is_multi,
  input wire logic accept_single_card,
  input wire logic discharge_on_removal,
  input wire logic discharge_on_powerup,
  // card events from the host's slot logic
  input wire logic card_present,
  input wire logic card_is_multi,
  input wire logic id_done,
  input wire logic id_multi,
  input wire logic id_channel_one_support,
  input wire logic info_request,
  input wire logic info_grant,
  // switch fault line, active low
  input wire logic fault_n,
  // select lines to the switch
  output logic state_select_bit0,
  output logic state_select_bit1,
  output logic state_select_bit2,
  // status
  output logic card_reset,
  output logic single_mode,
  output logic fault_seen
);

  typedef struct packed {
    seq_state_t st;
    logic [2:0] code;
    logic card_reset;
    logic single_mode;
    logic fault;
  } host_t;

  host_t cur_q;
  host_t nxt_d;
  logic dwell_load;
  logic dwell_done;

  // select code for each state
  function automatic logic [2:0] code_of(input seq_state_t s); // RULE_03
    case (s)
      ST_S_HIGH: code_of = CODE_AUX_HIGH;
      ST_S_DISCH: code_of = CODE_AUX_DISCH;
      ST_M_PWRUP_DISCH: code_of = CODE_ALL_GND;
      ST_M_DISCH: code_of = CODE_ALL_GND;
      ST_M_NO_CARD: code_of = CODE_ALL_OPEN;
      ST_M_UNPOWERED: code_of = CODE_ALL_OPEN;
      ST_M_DETECT: code_of = CODE_HOST_SIG;
      ST_M_ON: code_of = CODE_MULTI_ON;
      default: code_of = CODE_ALL_LOW;
    endcase
  endfunction : code_of

  dwell_timer u_dwell (
    .clk(clk),
    .rst(rst),
    .load(dwell_load),
    .expired(dwell_done)
  );

  // sequencer next state
  always_comb
  begin
    nxt_d = cur_q;
    dwell_load = 1'b0;
    nxt_d.card_reset = 1'b0;
    nxt_d.fault = !fault_n;
    case (cur_q.st)
      ST_S_IDLE: // RULE_06
      begin
        if (card_present && info_request && info_grant)
        begin
          nxt_d.st = ST_S_HIGH; // RULE_08
        end
        else if (card_present && info_request)
        begin
          nxt_d.st = ST_S_REFUSED; // RULE_07
        end
      end
      ST_S_HIGH:
      begin
        if (!card_present)
        begin
          dwell_load = discharge_on_removal;
          nxt_d.st = discharge_on_removal ? ST_S_DISCH : ST_S_IDLE; // RULE_09
        end
      end
      ST_S_REFUSED:
      begin
        if (!card_present)
        begin
          nxt_d.st = ST_S_IDLE; // RULE_07
        end
      end
      ST_S_DISCH:
      begin
        if (dwell_done)
        begin
          nxt_d.st = ST_S_IDLE; // RULE_09
        end
      end
      ST_M_PWRUP_DISCH:
      begin
        if (dwell_done)
        begin
          nxt_d.st = ST_M_NO_CARD; // RULE_10
        end
      end
      ST_M_NO_CARD:
      begin
        if (card_present && card_is_multi)
        begin
          nxt_d.st = ST_M_DETECT; // RULE_12
        end
        else if (card_present)
        begin
          nxt_d.st = ST_M_UNPOWERED; // RULE_11
        end
      end
      ST_M_DETECT:
      begin
        if (!card_present)
        begin
          dwell_load = 1'b1;
          nxt_d.st = ST_M_DISCH;
        end
        else if (id_done && id_multi)
        begin
          nxt_d.st = ST_M_ON; // RULE_13
        end
        else if (id_done && id_channel_one_support && accept_single_card)
        begin
          nxt_d.st = ST_S_IDLE; // RULE_14
          nxt_d.single_mode = 1'b1; // RULE_05
          nxt_d.card_reset = 1'b1;
        end
        else if (id_done)
        begin
          nxt_d.st = ST_M_UNPOWERED; // RULE_15
        end
      end
      ST_M_ON,
      ST_M_UNPOWERED:
      begin
        if (!card_present)
        begin
          dwell_load = 1'b1;
          nxt_d.st = ST_M_DISCH; // RULE_16
        end
      end
      ST_M_DISCH:
      begin
        if (dwell_done)
        begin
          nxt_d.st = ST_M_NO_CARD; // RULE_16
        end
      end
      default:
      begin
        nxt_d.st = ST_S_IDLE;
      end
    endcase
    // single mode entered from a multi host ends with the card
    if (cur_q.single_mode && !card_present && nxt_d.st == ST_S_IDLE)
    begin
      nxt_d.st = ST_M_NO_CARD;
      nxt_d.single_mode = 1'b0;
    end
    // power-up choice taken once, after reset release
    if (cur_q.code == CODE_RESET && cur_q.st == ST_S_IDLE && !cur_q.single_mode
        && host_is_multi)
    begin
      dwell_load = discharge_on_powerup;
      nxt_d.st = discharge_on_powerup ? ST_M_PWRUP_DISCH : ST_M_NO_CARD; // RULE_04
    end
    nxt_d.code = code_of(nxt_d.st); // RULE_18
  end

  // one register holds all sequencer state; the code bits move together
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_q.st <= ST_S_IDLE;
      cur_q.code <= CODE_RESET;
      cur_q.card_reset <= 1'b0;
      cur_q.single_mode <= 1'b0;
      cur_q.fault <= 1'b0;
    end
    else
    begin
      cur_q <= nxt_d; // RULE_18
    end
  end

  // outputs straight from the register
  assign state_select_bit0 = cur_q.code[0];
  assign state_select_bit1 = cur_q.code[1];
  assign state_select_bit2 = cur_q.code[2];
  assign card_reset = cur_q.card_reset;
  assign single_mode = cur_q.single_mode;
  assign fault_seen = cur_q.fault;

  // single host leaves 000 only for a granted request or discharge
  a_single_hold: assert property (@(posedge clk) disable iff (rst) // RULE_06
    (cur_q.st == ST_S_IDLE && !(card_present && info_request))
    |=> (cur_q.code == CODE_ALL_LOW || cur_q.code == CODE_ALL_OPEN
         || cur_q.code == CODE_ALL_GND))
    else $error("single host left 000 without a request");

  a_refused_stays: assert property (@(posedge clk) disable iff (rst) // RULE_07
    cur_q.st == ST_S_REFUSED |-> cur_q.code == CODE_ALL_LOW)
    else $error("refused request did not hold 000");

  a_grant_moves: assert property (@(posedge clk) disable iff (rst) // RULE_08
    (cur_q.st == ST_S_IDLE && card_present && info_request && info_grant)
    |=> cur_q.code == CODE_AUX_HIGH)
    else $error("granted request did not give 001");

  a_high_holds: assert property (@(posedge clk) disable iff (rst) // RULE_08
    (cur_q.code == CODE_AUX_HIGH && card_present) |=> cur_q.code == CODE_AUX_HIGH)
    else $error("left 001 while card present");

  sequence s_removed_on;
    cur_q.st == ST_M_ON && !card_present;
  endsequence

  a_multi_removal: assert property (@(posedge clk) disable iff (rst) // RULE_16
    s_removed_on |=> cur_q.code == CODE_ALL_GND [*8])
    else $error("removal did not discharge through 111");

  a_discharge_end: assert property (@(posedge clk) disable iff (rst) // RULE_16
    (cur_q.st == ST_M_DISCH && dwell_done) |=> cur_q.code == CODE_ALL_OPEN)
    else $error("discharge did not end at 010");

  a_detect_code: assert property (@(posedge clk) disable iff (rst) // RULE_12
    (cur_q.st == ST_M_NO_CARD && card_present && card_is_multi)
    |=> cur_q.code == CODE_HOST_SIG)
    else $error("multi card detect did not give 011");

  a_id_multi: assert property (@(posedge clk) disable iff (rst) // RULE_13
    (cur_q.st == ST_M_DETECT && card_present && id_done && id_multi)
    |=> cur_q.code == CODE_MULTI_ON)
    else $error("identified multi card did not give 100");

  a_no_power: assert property (@(posedge clk) disable iff (rst) // RULE_15
    cur_q.st == ST_M_UNPOWERED |-> cur_q.code == CODE_ALL_OPEN)
    else $error("unaccepted card was powered");

  a_single_reset: assert property (@(posedge clk) disable iff (rst) // RULE_14
    $rose(cur_q.single_mode) |-> cur_q.card_reset && cur_q.code == CODE_ALL_LOW)
    else $error("single mode entry without card reset");

endmodule : slot_power_host

// [verilog/slot_power_pkg.sv]
package slot_power_pkg;

  // select codes driven to the power switch
  localparam logic [2:0] CODE_ALL_LOW = 3'h0;
  localparam logic [2:0] CODE_AUX_HIGH = 3'h1;
  localparam logic [2:0] CODE_ALL_OPEN = 3'h2;
  localparam logic [2:0] CODE_HOST_SIG = 3'h3;
  localparam logic [2:0] CODE_MULTI_ON = 3'h4;
  localparam logic [2:0] CODE_AUX_DISCH = 3'h6;
  localparam logic [2:0] CODE_ALL_GND = 3'h7;

  // value of the select code while reset is applied
  localparam logic [2:0] CODE_RESET = 3'h2;

  // discharge dwell times in microseconds and their cycle counts at 20 MHz
  localparam int CLK_MHZ = 20;
  localparam int DISCH_US = 100;
  localparam int DISCH_CYCLES = DISCH_US * CLK_MHZ;
  localparam int DWELL_W = 12;
  localparam logic [DWELL_W-1:0] DWELL_LOAD = DWELL_W'(DISCH_CYCLES - 1);
  localparam logic [DWELL_W-1:0] DWELL_ZERO = 12'h000;

  // sequencer states
  typedef enum logic [3:0] {
    ST_S_IDLE,
    ST_S_HIGH,
    ST_S_REFUSED,
    ST_S_DISCH,
    ST_M_PWRUP_DISCH,
    ST_M_NO_CARD,
    ST_M_DETECT,
    ST_M_ON,
    ST_M_UNPOWERED,
    ST_M_DISCH
  } seq_state_t;

endpackage : slot_power_pkg
